//--- hw/sscacc_cfg.svh
// Register map, field positions, reset values and widths of the stall counter/accumulator.
// Assumes word addressing on a 32-bit Avalon-MM bus.
`ifndef SSCACC_CFG_SVH
`define SSCACC_CFG_SVH

// ----------------------------------------------------------------
// Register word indices
// ----------------------------------------------------------------
`define SSCACC_IDX_FLAGS   3'h0
`define SSCACC_IDX_COUNT   3'h1
`define SSCACC_IDX_CTRL    3'h2
`define SSCACC_IDX_ACCUM   3'h3
`define SSCACC_IDX_RTZ     3'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSCACC_FLG_CZ      7
`define SSCACC_FLG_AOV     0
`define SSCACC_CTL_RLS     0
`define SSCACC_CTL_ARM     1
`define SSCACC_CTL_CZIE    2
`define SSCACC_CTL_ACCUM_OVERFLOW_IRQ_ENABLE   3
`define SSCACC_RTZ_STEP    0
`define SSCACC_RTZ_POL     2
`define SSCACC_RTZ_BLANK   3
`define SSCACC_RTZ_DRIVE   4
`define SSCACC_RTZ_INTEG   5

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define SSCACC_CTL_W       4
`define SSCACC_RTZ_W       6
`define SSCACC_SMP_W       8
`define SSCACC_RST_CNT     16'h0000
`define SSCACC_RST_CTL     4'h0
`define SSCACC_RST_RTZ     6'h08
`define SSCACC_RST_ACC     16'h0000

`endif

//--- hw/sscacc_pkg.sv
// Types shared by the stall counter/accumulator design.
// Assumes nothing beyond the config header.
`default_nettype none

package sscacc_pkg;
    // Signed integration result
    typedef logic signed [15:0] sscacc_acc_t;
    // Unsigned count word
    typedef logic [15:0] sscacc_cnt_t;
    // Full step states, one coil driven each
    typedef enum logic [1:0] {
        STEP_A_POS,
        STEP_B_POS,
        STEP_A_NEG,
        STEP_B_NEG
    } sscacc_step_t;
endpackage

`default_nettype wire

//--- hw/sscacc_counter.sv
// Modulus down-counter with load register and auto-reload.
// Assumes load is a one-cycle strobe from the register slave.
`default_nettype none
`include "sscacc_cfg.svh"

module sscacc_counter
    import sscacc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Load strobe and mode
    input  wire logic        load,
    input  wire sscacc_cnt_t load_value,
    input  wire logic        auto_reload,
    // State and event
    output sscacc_cnt_t      count,
    output sscacc_cnt_t      reload,
    output logic             zero_event
);
    sscacc_cnt_t next_count;
    sscacc_cnt_t next_reload;

    // ----------------------------------------------------------------
    // Next count
    // ----------------------------------------------------------------
    always_comb begin
        next_count  = count;
        next_reload = reload;
        zero_event  = 1'b0;
        if (count == 16'h0001) begin
            zero_event = 1'b1;
            next_count = auto_reload ? reload : 16'h0000;
        end else if (count != 16'h0000) begin
            next_count = count - 16'h0001;
        end else if (auto_reload && reload != 16'h0000) begin
            next_count = reload;
        end
        // Write: auto mode touches only the load register
        if (load) begin
            next_reload = load_value;
            if (!auto_reload) begin
                next_count = load_value;
                zero_event = 1'b0;
            end
        end
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count  <= `SSCACC_RST_CNT;
            reload <= `SSCACC_RST_CNT;
        end else begin
            count  <= next_count;
            reload <= next_reload;
        end
    end
endmodule // sscacc_counter

`default_nettype wire

//--- hw/sscacc_top.sv
// Stall detector digital core: down-counter, back-EMF accumulator, flags, coil drive.
// Assumes integrator samples arrive on clk; software decides stall from the accumulator.
// Operation
// - Keep integration result in signed 16-bit accumulator
// - Provide 16-bit down-counter for blanking, integration
// - Integrate only after blanking, never during it
// - Full steps drive exactly one coil
// - Counter reaching zero sets bit 7 flag
// - Counter irq while flag and enable set
// - Writing one clears flag, zero ignored
// - Overflow either sign sets bit 0 flag
// - Overflow irq while flag and enable set
// - Select clear: counter read returns live count
// - Select set: counter read returns reload value
// - Auto off: writing zero stops counter, no flag
// - Auto off: write loads reload and count
// - Auto on: write updates reload only
// - Word access is one operation; counter byte writes merge with reload
`default_nettype none
`include "sscacc_cfg.svh"

module sscacc_top
    import sscacc_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // Avalon-MM slave
    input  wire logic [2:0]               address,
    input  wire logic                     read,
    input  wire logic                     write,
    input  wire logic [31:0]              writedata,
    input  wire logic [3:0]               byteenable,
    output logic      [31:0]              readdata,
    output logic                          waitrequest,
    // Integrator front end
    input  wire logic                     integ_valid,
    input  wire logic signed [`SSCACC_SMP_W-1:0] integ_sample,
    // Coil drive and sensing
    output logic                          coil_a_drive,
    output logic                          coil_a_neg,
    output logic                          coil_b_drive,
    output logic                          coil_b_neg,
    output logic                          sense_coil_b,
    output logic                          integrating,
    // Interrupt requests
    output logic                          cz_irq,
    output logic                          aov_irq
);
    // Register index match
    function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
        hit = (a == idx);
    endfunction

    logic                      next_waitrequest;
    logic [31:0]               next_readdata;
    logic [31:0]               rd_mux;
    logic                      wr_commit;
    logic [`SSCACC_CTL_W-1:0]  ctl;
    logic [`SSCACC_CTL_W-1:0]  next_ctl;
    logic [`SSCACC_RTZ_W-1:0]  return_to_zero;
    logic [`SSCACC_RTZ_W-1:0]  next_rtz;
    sscacc_acc_t               acc;
    sscacc_acc_t               next_acc;
    logic                      acc_ovf;
    logic signed [16:0]        term;
    logic signed [16:0]        sum;
    logic                      cnt_load;
    sscacc_cnt_t               cnt_wdata;
    sscacc_cnt_t               count;
    sscacc_cnt_t               reload;
    logic                      zero_event;
    logic [1:0]                flag;
    logic [1:0]                next_flag;
    logic [1:0]                flag_set;
    logic [1:0]                flag_clr;
    sscacc_step_t              step;
    logic                      next_a_drv;
    logic                      next_a_neg;
    logic                      next_b_drv;
    logic                      next_b_neg;
    logic                      next_integ;

    // ----------------------------------------------------------------
    // Avalon slave: one wait cycle, write commits when waitrequest is low
    // ----------------------------------------------------------------
    always_comb begin
        next_waitrequest = !((read || write) && waitrequest);
        wr_commit        = write && !waitrequest;
        rd_mux           = 32'h0000_0000;
        unique case (address)
            `SSCACC_IDX_FLAGS: begin
                rd_mux[`SSCACC_FLG_CZ]  = flag[1];
                rd_mux[`SSCACC_FLG_AOV] = flag[0];
            end
            `SSCACC_IDX_COUNT: begin
                rd_mux[15:0] = ctl[`SSCACC_CTL_RLS] ? reload : count;
            end
            `SSCACC_IDX_CTRL:  rd_mux[`SSCACC_CTL_W-1:0] = ctl;
            `SSCACC_IDX_ACCUM: rd_mux[15:0] = acc;
            `SSCACC_IDX_RTZ:   rd_mux[`SSCACC_RTZ_W-1:0] = return_to_zero;
            default:           rd_mux = 32'h0000_0000;
        endcase
        // Capture the selected word in the wait cycle, while waitrequest is still high
        next_readdata    = (read && waitrequest) ? rd_mux : readdata;
    end

    // Bus registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end else begin
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    // ----------------------------------------------------------------
    // Control and step registers
    // ----------------------------------------------------------------
    always_comb begin
        next_ctl = ctl;
        next_rtz = return_to_zero;
        if (wr_commit && byteenable[0] && hit(address, `SSCACC_IDX_CTRL)) begin
            next_ctl = writedata[`SSCACC_CTL_W-1:0];
        end
        if (wr_commit && byteenable[0] && hit(address, `SSCACC_IDX_RTZ)) begin
            next_rtz = writedata[`SSCACC_RTZ_W-1:0];
        end
    end

    // Control register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl <= `SSCACC_RST_CTL;
            return_to_zero <= `SSCACC_RST_RTZ;
        end else begin
            ctl <= next_ctl;
            return_to_zero <= next_rtz;
        end
    end

    // ----------------------------------------------------------------
    // Down-counter; a lone byte write merges with the load register
    // ----------------------------------------------------------------
    always_comb begin
        cnt_load  = wr_commit && hit(address, `SSCACC_IDX_COUNT) && (|byteenable[1:0]);
        cnt_wdata = {byteenable[1] ? writedata[15:8] : reload[15:8],
                     byteenable[0] ? writedata[7:0]  : reload[7:0]};
    end

    sscacc_counter u_counter (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .load        (cnt_load),
        .load_value  (cnt_wdata),
        .auto_reload (ctl[`SSCACC_CTL_ARM]),
        .count       (count),
        .reload      (reload),
        .zero_event  (zero_event)
    );

    // ----------------------------------------------------------------
    // Accumulator: signed add with polarity, overflow of either sign
    // ----------------------------------------------------------------
    always_comb begin
        term     = 17'(integ_sample);
        if (return_to_zero[`SSCACC_RTZ_POL]) begin
            term = -term;
        end
        sum      = {acc[15], acc} + term;
        acc_ovf  = 1'b0;
        next_acc = acc;
        if (integ_valid && return_to_zero[`SSCACC_RTZ_INTEG] && !return_to_zero[`SSCACC_RTZ_BLANK]) begin
            next_acc = sum[15:0];
            acc_ovf  = sum[16] ^ sum[15];
        end
        if (wr_commit && hit(address, `SSCACC_IDX_ACCUM) && (&byteenable[1:0])) begin
            next_acc = writedata[15:0];
        end
    end

    // Accumulator stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc <= `SSCACC_RST_ACC;
        end else begin
            acc <= next_acc;
        end
    end

    // ----------------------------------------------------------------
    // Flags: hardware set wins over a write-one clear
    // ----------------------------------------------------------------
    assign flag_set = {zero_event, acc_ovf};
    assign flag_clr = {writedata[`SSCACC_FLG_CZ], writedata[`SSCACC_FLG_AOV]};

    for (genvar i = 0; i < 2; i++) begin : g_flag
        // One flag bit
        always_comb begin
            next_flag[i] = flag[i];
            if (wr_commit && byteenable[0] && hit(address, `SSCACC_IDX_FLAGS) && flag_clr[i]) begin
                next_flag[i] = 1'b0;
            end
            if (flag_set[i]) begin
                next_flag[i] = 1'b1;
            end
        end
        // Flag stage
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                flag[i] <= 1'b0;
            end else begin
                flag[i] <= next_flag[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Coil drive decode and interrupt requests
    // ----------------------------------------------------------------
    always_comb begin
        step       = sscacc_step_t'(next_rtz[`SSCACC_RTZ_STEP +: 2]);
        next_a_drv = 1'b0;
        next_b_drv = 1'b0;
        next_a_neg = 1'b0;
        next_b_neg = 1'b0;
        unique case (step)
            STEP_A_POS: next_a_drv = next_rtz[`SSCACC_RTZ_DRIVE];
            STEP_B_POS: next_b_drv = next_rtz[`SSCACC_RTZ_DRIVE];
            STEP_A_NEG: begin
                next_a_drv = next_rtz[`SSCACC_RTZ_DRIVE];
                next_a_neg = 1'b1;
            end
            STEP_B_NEG: begin
                next_b_drv = next_rtz[`SSCACC_RTZ_DRIVE];
                next_b_neg = 1'b1;
            end
        endcase
        next_integ = next_rtz[`SSCACC_RTZ_INTEG] && !next_rtz[`SSCACC_RTZ_BLANK];
    end

    // Output stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            coil_a_drive <= 1'b0;
            coil_a_neg   <= 1'b0;
            coil_b_drive <= 1'b0;
            coil_b_neg   <= 1'b0;
            sense_coil_b <= 1'b1;
            integrating  <= 1'b0;
            cz_irq       <= 1'b0;
            aov_irq      <= 1'b0;
        end else begin
            coil_a_drive <= next_a_drv;
            coil_a_neg   <= next_a_neg;
            coil_b_drive <= next_b_drv;
            coil_b_neg   <= next_b_neg;
            sense_coil_b <= !next_rtz[`SSCACC_RTZ_STEP];
            integrating  <= next_integ;
            cz_irq       <= next_flag[1] && next_ctl[`SSCACC_CTL_CZIE];
            aov_irq      <= next_flag[0] && next_ctl[`SSCACC_CTL_ACCUM_OVERFLOW_IRQ_ENABLE];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_cz_flag_set: assert property (zero_event |=> flag[1])
        else $error("counter zero did not set flag");
    a_cz_irq_lvl: assert property (cz_irq == (flag[1] && ctl[`SSCACC_CTL_CZIE]))
        else $error("counter irq does not follow flag and enable");
    a_aov_irq_lvl: assert property (aov_irq == (flag[0] && ctl[`SSCACC_CTL_ACCUM_OVERFLOW_IRQ_ENABLE]))
        else $error("overflow irq does not follow flag and enable");
    a_flag_w0_keep: assert property (wr_commit && hit(address, `SSCACC_IDX_FLAGS) && flag[1]
        && !writedata[`SSCACC_FLG_CZ] |=> flag[1])
        else $error("writing zero cleared counter flag");
    a_aov_flag_set: assert property (acc_ovf |=> flag[0])
        else $error("overflow did not set flag");
    a_blank_hold: assert property (return_to_zero[`SSCACC_RTZ_BLANK] && !(wr_commit && hit(address, `SSCACC_IDX_ACCUM))
        |=> acc == $past(acc))
        else $error("accumulator moved during blanking");
    a_one_coil: assert property (!(coil_a_drive && coil_b_drive))
        else $error("both coils driven");
    a_count_down: assert property (count > 16'h0001 && !cnt_load |=> count == $past(count) - 16'h0001)
        else $error("counter did not decrement");
    a_zero_write: assert property (cnt_load && cnt_wdata == 16'h0000 && !ctl[`SSCACC_CTL_ARM]
        |=> count == 16'h0000 ##1 (!flag[1] || $past(flag[1])))
        else $error("zero write misbehaved");
    a_direct_load: assert property (cnt_load && !ctl[`SSCACC_CTL_ARM] |=> count == $past(cnt_wdata)
        && reload == $past(cnt_wdata))
        else $error("direct load failed");
    a_auto_keep: assert property (cnt_load && ctl[`SSCACC_CTL_ARM] && count > 16'h0001
        |=> count == $past(count) - 16'h0001 && reload == $past(cnt_wdata))
        else $error("auto mode write disturbed count");
    a_auto_reload: assert property (ctl[`SSCACC_CTL_ARM] && count == 16'h0001 && !cnt_load
        |=> count == $past(reload) && flag[1])
        else $error("auto reload failed");
    a_read_select: assert property (read && waitrequest && hit(address, `SSCACC_IDX_COUNT)
        |=> !waitrequest && readdata[15:0] == ($past(ctl[`SSCACC_CTL_RLS]) ? $past(reload) : $past(count)))
        else $error("counter read returned wrong source");

    c_auto_wrap: cover property (ctl[`SSCACC_CTL_ARM] && zero_event ##[1:20] zero_event);
    c_acc_ovf: cover property (acc_ovf && return_to_zero[`SSCACC_RTZ_POL]);
    c_read_reload: cover property (read && !waitrequest && ctl[`SSCACC_CTL_RLS]);
    c_clear_race: cover property (flag_set[1] && wr_commit && hit(address, `SSCACC_IDX_FLAGS));
endmodule // sscacc_top

`default_nettype wire

//--- tb/sscacc_integ_model.sv
// Behavioural integrator front end that feeds back-EMF samples to the stall core.
// Assumes the bench calls send_samples right after a rising clock edge.
`default_nettype none

module sscacc_integ_model (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Sample stream
    output var  logic              integ_valid,
    output var  logic signed [7:0] integ_sample
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle lines show the inverse of the last sample, never a stale copy
    initial begin
        integ_valid  = 1'b0;
        integ_sample = 8'h00;
    end

    // ------------------------------------------------------------
    // Sends n samples, each valid one cycle, gap idle cycles between
    // ------------------------------------------------------------
    task automatic send_samples(input int n, input logic signed [7:0] s, input int gap);
        for (int i = 0; i < n; i++) begin
            integ_valid  <= 1'b1;
            integ_sample <= s;
            @(posedge clk);
            // With no gap the next sample follows in the very next cycle
            if (gap > 0) begin
                integ_valid  <= 1'b0;
                integ_sample <= ~s;
                repeat (gap) @(posedge clk);
            end
        end
        integ_valid  <= 1'b0;
        integ_sample <= ~s;
    endtask
endmodule // sscacc_integ_model

`default_nettype wire

//--- tb/stepper_stall_counter_accumulator_tb.sv
// Self-checking bench for the stall counter/accumulator core over its Avalon-MM slave.
// Assumes the register map of the config header and the integrator model beside it.
`default_nettype none
`include "sscacc_cfg.svh"

module stepper_stall_counter_accumulator_tb;
    import sscacc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and bus
    logic              clk;
    logic              sys_rst;
    logic [2:0]        address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
    logic [31:0]       readdata;
    logic              waitrequest;
    // Front end and drive outputs
    logic              integ_valid;
    logic signed [7:0] integ_sample;
    logic              coil_a_drive, coil_a_neg, coil_b_drive, coil_b_neg;
    logic              sense_coil_b, integrating, cz_irq, aov_irq;
    int                bad_count;
    int                checks;
    logic [31:0]       q;

    sscacc_top i_sscacc_top (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .integ_valid(integ_valid), .integ_sample(integ_sample), .coil_a_drive(coil_a_drive),
        .coil_a_neg(coil_a_neg), .coil_b_drive(coil_b_drive), .coil_b_neg(coil_b_neg),
        .sense_coil_b(sense_coil_b), .integrating(integrating), .cz_irq(cz_irq), .aov_irq(aov_irq));

    sscacc_integ_model i_sscacc_integ_model (.clk(clk), .sys_rst(sys_rst), .integ_valid(integ_valid),
        .integ_sample(integ_sample));

    // 250 MHz clock
    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Bus access, comparison and verdict tasks
    // ------------------------------------------------------------
    task automatic bus(input logic [2:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        address    <= a;
        write      <= wr;
        read       <= ~wr;
        writedata  <= d;
        byteenable <= be;
        // Hold the request until waitrequest is sampled low; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [3:0] be = 4'h3);
        bus(a, 1'b1, {16'h0000, d}, be);
    endtask

    task automatic expect_ok(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Reads a register and compares its low half
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string msg);
        bus(a, 1'b0, 32'h0000_0000, 4'hF);
        expect_ok(q[15:0] === exp, msg);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog far beyond the roughly 1300 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0; sys_rst = 1'b1; address = 3'h0; read = 1'b0; write = 1'b0;
        writedata = 32'h0000_0000; byteenable = 4'h0; bad_count = 0; checks = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values and an unmapped index
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0000, "flags reset");
        rd_chk(`SSCACC_IDX_COUNT, 16'h0000, "count reset");
        rd_chk(`SSCACC_IDX_CTRL, 16'h0000, "ctrl reset");
        rd_chk(`SSCACC_IDX_ACCUM, 16'h0000, "accum reset");
        rd_chk(`SSCACC_IDX_RTZ, 16'h0008, "rtz reset");
        wr(3'h5, 16'h00FF);
        rd_chk(3'h5, 16'h0000, "unmapped read");
        $display("test reset done");

        // One-shot count, flag, irq and write-one clear
        wr(`SSCACC_IDX_CTRL, 16'h0004);
        wr(`SSCACC_IDX_COUNT, 16'h0014);
        bus(`SSCACC_IDX_COUNT, 1'b0, 32'h0000_0000, 4'hF);
        expect_ok(q[15:0] < 16'h0014 && q[15:0] > 16'h0000, "live count");
        wr(`SSCACC_IDX_CTRL, 16'h0005);
        rd_chk(`SSCACC_IDX_COUNT, 16'h0014, "reload value");
        repeat (30) @(posedge clk);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0080, "zero flag set");
        expect_ok(cz_irq === 1'b1, "counter irq");
        wr(`SSCACC_IDX_CTRL, 16'h0004);
        rd_chk(`SSCACC_IDX_COUNT, 16'h0000, "halt at zero");
        wr(`SSCACC_IDX_FLAGS, 16'h0000);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0080, "zero write kept flag");
        wr(`SSCACC_IDX_FLAGS, 16'h0080);
        @(posedge clk);
        expect_ok(cz_irq === 1'b0, "irq after clear");
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0000, "flag cleared");
        wr(`SSCACC_IDX_COUNT, 16'h0000);
        repeat (10) @(posedge clk);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0000, "zero load no flag");
        $display("test one_shot done");

        // Auto-reload: write reaches reload only, then reload at zero
        wr(`SSCACC_IDX_COUNT, 16'h03E8);
        wr(`SSCACC_IDX_CTRL, 16'h0006);
        wr(`SSCACC_IDX_COUNT, 16'h0005);
        bus(`SSCACC_IDX_COUNT, 1'b0, 32'h0000_0000, 4'hF);
        expect_ok(q[15:0] > 16'h0384 && q[15:0] < 16'h03E8, "count kept");
        repeat (1000) @(posedge clk);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0080, "auto flag");
        bus(`SSCACC_IDX_COUNT, 1'b0, 32'h0000_0000, 4'hF);
        expect_ok(q[15:0] <= 16'h0005 && q[15:0] > 16'h0000, "reloaded count");
        wr(`SSCACC_IDX_FLAGS, 16'h0080);
        repeat (10) @(posedge clk);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0080, "keeps counting");
        wr(`SSCACC_IDX_CTRL, 16'h0000);
        // Let the last short period run out before clearing the flag
        repeat (10) @(posedge clk);
        rd_chk(`SSCACC_IDX_COUNT, 16'h0000, "stops once auto is off");
        wr(`SSCACC_IDX_FLAGS, 16'h0080);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0000, "flag clear after stop");
        $display("test auto_reload done");

        // Byte write merges with the other half of the reload word
        wr(`SSCACC_IDX_COUNT, 16'h1234);
        wr(`SSCACC_IDX_COUNT, 16'h0056, 4'h1);
        wr(`SSCACC_IDX_CTRL, 16'h0001);
        rd_chk(`SSCACC_IDX_COUNT, 16'h1256, "byte write merge");
        wr(`SSCACC_IDX_CTRL, 16'h0008);
        $display("test byte_access done");

        // Integration only outside blanking, polarity and overflow both ways
        wr(`SSCACC_IDX_RTZ, 16'h0038);
        @(posedge clk);
        expect_ok(integrating === 1'b0, "no integration in blanking");
        i_sscacc_integ_model.send_samples(4, 8'sh0A, 0);
        rd_chk(`SSCACC_IDX_ACCUM, 16'h0000, "blanked samples ignored");
        wr(`SSCACC_IDX_RTZ, 16'h0030);
        @(posedge clk);
        expect_ok(integrating === 1'b1, "integrating");
        i_sscacc_integ_model.send_samples(4, 8'sh0A, 2);
        rd_chk(`SSCACC_IDX_ACCUM, 16'h0028, "sum of samples");
        wr(`SSCACC_IDX_RTZ, 16'h0034);
        i_sscacc_integ_model.send_samples(10, 8'sh05, 0);
        rd_chk(`SSCACC_IDX_ACCUM, 16'hFFF6, "signed result");
        wr(`SSCACC_IDX_ACCUM, 16'h7FF0);
        wr(`SSCACC_IDX_RTZ, 16'h0030);
        i_sscacc_integ_model.send_samples(1, 8'sh20, 0);
        rd_chk(`SSCACC_IDX_ACCUM, 16'h8010, "positive wrap");
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0001, "positive overflow");
        expect_ok(aov_irq === 1'b1, "overflow irq");
        wr(`SSCACC_IDX_FLAGS, 16'h0001);
        @(posedge clk);
        expect_ok(aov_irq === 1'b0, "overflow irq cleared");
        wr(`SSCACC_IDX_ACCUM, 16'h8005);
        wr(`SSCACC_IDX_RTZ, 16'h0034);
        i_sscacc_integ_model.send_samples(1, 8'sh10, 0);
        rd_chk(`SSCACC_IDX_FLAGS, 16'h0001, "negative overflow");
        wr(`SSCACC_IDX_FLAGS, 16'h0001);
        $display("test integrate done");

        // Each full step drives one coil and senses the other
        for (int s = 0; s < 4; s++) begin
            wr(`SSCACC_IDX_RTZ, 16'h0010 | 16'(s));
            @(posedge clk);
            expect_ok({coil_a_drive, coil_a_neg, coil_b_drive, coil_b_neg, sense_coil_b} ===
                {~s[0], ~s[0] & s[1], s[0], s[0] & s[1], ~s[0]}, "coil pattern");
        end
        $display("test full_step done");
        give_verdict();
    end
endmodule // stepper_stall_counter_accumulator_tb

`default_nettype wire
